// ===== rtl/pcw_codec.sv
/*
 parameter channel word codec: decodes a four word request and
 encodes a response.  assumes a register port master on SYS_CLK
 that keeps strobes one cycle long and never both at once.
*/
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pcw_map.svh"

// Summary of operation
// RULE1: numbers below 2000 sit unchanged
// RULE2: higher numbers carry number minus offset
// RULE3: offsets 0,2000,6000,8000 coded in page
// RULE4: offsets 10000 to 60000 coded likewise
// RULE5: subindex in second word high byte
// RULE6: byte value low, rest zero
// RULE7: word value in fourth word
// RULE8: double word high third, low fourth
// RULE9: connector number, object and index layout
// RULE10: controller puts request id in top
// RULE11: read requests leave value words zero
// RULE12: connector drive object always 63
// RULE13: request ids decoded per table
// RULE14: failure answers id 7 with error
// RULE15: bit 11 of key ignored
// RULE16: rebuild number; unknown page illegal
module pcw_codec
    import pcw_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        CLK_EN,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output var  logic [15:0] RDATA,
    output var  logic        IRQ,
    output var  logic        DONE
);
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
    logic [15:0] w4;
    logic [15:0] pnum;
    logic [15:0] rsp1;
    logic [15:0] rsp4;
    logic [15:0] val_hi;
    logic [15:0] val_lo;
    logic [7:0]  decode;
    logic [7:0]  subidx;
    logic [2:0]  status;
    logic [2:0]  mask;
    pcw_state_t  state;
    pcw_state_t  next_state;

    pcw_key_t    key;
    pcw_index_t  idx;
    pcw_conn_t   conn;
    assign key  = pcw_key_t'(w1);
    assign idx  = pcw_index_t'(w2);
    assign conn = pcw_conn_t'(w4);
    wire  [5:0]  obj_field = conn.drive_object;
    wire  [7:0]  sub_field = idx.subindex;

    wire         wr_ctrl   = WR && (ADDR == `PCW_ADDR_CTRL);
    wire         go        = wr_ctrl && WDATA[0];
    wire         wr_mask   = WR && (ADDR == `PCW_ADDR_MASK);
    wire  [2:0]  next_mask = wr_mask ? WDATA[2:0] : mask;

    // RULE3: low range page codes
    // RULE4: high range page codes
    logic [15:0] offset;
    logic        page_ok;
    always_comb begin
        page_ok = 1'b1;
        case (idx.page_index)
            `PCW_PG_0:     offset = 16'h0000;
            `PCW_PG_2000:  offset = `PCW_OFS_2000;
            `PCW_PG_6000:  offset = `PCW_OFS_6000;
            `PCW_PG_8000:  offset = `PCW_OFS_8000;
            `PCW_PG_10000: offset = `PCW_OFS_10000;
            `PCW_PG_20000: offset = `PCW_OFS_20000;
            `PCW_PG_30000: offset = `PCW_OFS_30000;
            `PCW_PG_60000: offset = `PCW_OFS_60000;
            default: begin
                offset  = 16'h0000;
                page_ok = 1'b0;
            end
        endcase
    end

    // RULE1: number field below 2000
    // RULE2: offset added for higher ranges
    // RULE15: bit 11 left out
    // RULE16: full number rebuilt
    wire  [15:0] full_num  = offset + {5'h00, key.param_number_field};

    // RULE13: request id decode
    logic        req_ok;
    logic        is_read;
    logic        is_dword;
    always_comb begin
        req_ok   = 1'b1;
        is_read  = 1'b0;
        is_dword = 1'b0;
        case (key.request_id_field)
            PCW_REQ_NONE:  is_read = 1'b0;
            PCW_REQ_READ,
            PCW_REQ_AREAD,
            PCW_REQ_DESC,
            PCW_REQ_COUNT: is_read = 1'b1;
            PCW_REQ_CHW,
            PCW_REQ_ACHW:  is_dword = 1'b0;
            PCW_REQ_CHD,
            PCW_REQ_ACHD:  is_dword = 1'b1;
            default:       req_ok = 1'b0;
        endcase
    end

    // RULE9: connector field split
    // RULE12: drive object check
    wire         conn_obj  = obj_field == `PCW_DRIVE_OBJ;
    wire         req_none  = key.request_id_field == PCW_REQ_NONE;
    // RULE6: byte value upper bits zero
    // RULE7: word value third word zero
    wire         is_word   = req_ok && !is_read && !is_dword;
    wire         is_conn   = is_word && !req_none && conn_obj;
    wire         word_bad  = is_word && !is_conn && (w3 != 16'h0000);
    wire         err_any   = !req_none && (!req_ok || !page_ok || word_bad);
    wire  [15:0] err_code  = !req_ok  ? `PCW_ERR_NO_TASK :
                             !page_ok ? `PCW_ERR_ILL_PNU :
                                        `PCW_ERR_DTYPE;
    // RULE8: double word value split
    // RULE11: read value words ignored
    wire  [15:0] nx_val_hi = (is_dword || is_conn) ? w3 : 16'h0000;
    wire  [15:0] nx_val_lo = is_read  ? 16'h0000 : w4;

    always_comb begin
        case (state)
            PCW_IDLE:   next_state = go ? PCW_DECODE : PCW_IDLE;
            PCW_DECODE: next_state = PCW_ANSWER;
            PCW_ANSWER: next_state = PCW_IDLE;
            default:    next_state = PCW_IDLE;
        endcase
    end

    wire         ev_done   = state == PCW_ANSWER;
    wire         ev_err    = (state == PCW_DECODE) && err_any;
    wire         ev_lost   = go && (state != PCW_IDLE);
    wire  [2:0]  ev        = {ev_lost, ev_err, ev_done};
    wire         wr_status = WR && (ADDR == `PCW_ADDR_STATUS);
    wire  [2:0]  next_status = (status & ~(wr_status ? WDATA[2:0] : 3'h0))
                               | ev;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= PCW_IDLE;
            pnum  <= 16'h0000;
            decode <= 8'h00;
            subidx <= 8'h00;
            rsp1  <= 16'h0000;
            rsp4  <= 16'h0000;
            val_hi <= 16'h0000;
            val_lo <= 16'h0000;
        end else if (CLK_EN) begin
            state <= next_state;
            if (state == PCW_DECODE) begin
                pnum   <= full_num;
                decode <= {3'h0, conn_obj, is_dword, is_read, page_ok,
                           req_ok};
                val_hi <= nx_val_hi;
                val_lo <= nx_val_lo;
                // RULE5: subindex latched
                subidx <= sub_field;
                // RULE14: error answer id 7
                if (err_any) begin
                    rsp1 <= {`PCW_RSP_ERROR, w1[11:0]};
                    rsp4 <= err_code;
                end else begin
                    rsp1 <= w1;
                    rsp4 <= nx_val_lo;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            w1 <= 16'h0000;
            w2 <= 16'h0000;
            w3 <= 16'h0000;
            w4 <= 16'h0000;
            mask <= 3'h0;
        end else if (CLK_EN && WR) begin
            if (ADDR == `PCW_ADDR_W1) w1 <= WDATA;
            if (ADDR == `PCW_ADDR_W2) w2 <= WDATA;
            if (ADDR == `PCW_ADDR_W3) w3 <= WDATA;
            if (ADDR == `PCW_ADDR_W4) w4 <= WDATA;
            if (ADDR == `PCW_ADDR_MASK) mask <= WDATA[2:0];
        end
    end

    logic [15:0] rmux;
    always_comb begin
        case (ADDR)
            `PCW_ADDR_CTRL:   rmux = {15'h0000, state != PCW_IDLE};
            `PCW_ADDR_STATUS: rmux = {13'h0000, status};
            `PCW_ADDR_MASK:   rmux = {13'h0000, mask};
            `PCW_ADDR_W1:     rmux = w1;
            `PCW_ADDR_W2:     rmux = w2;
            `PCW_ADDR_W3:     rmux = w3;
            `PCW_ADDR_W4:     rmux = w4;
            `PCW_ADDR_PNUM:   rmux = pnum;
            `PCW_ADDR_DECODE: rmux = {8'h00, decode};
            `PCW_ADDR_RSP1:   rmux = rsp1;
            `PCW_ADDR_RSP4:   rmux = rsp4;
            `PCW_ADDR_VAL_HI: rmux = val_hi;
            `PCW_ADDR_VAL_LO: rmux = val_lo;
            `PCW_ADDR_SUBIDX: rmux = {8'h00, subidx};
            default:          rmux = 16'h0000;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            status <= 3'h0;
            RDATA  <= 16'h0000;
            IRQ    <= 1'b0;
            DONE   <= 1'b0;
        end else if (CLK_EN) begin
            status <= next_status;
            RDATA  <= RD ? rmux : 16'h0000;
            IRQ    <= |(next_status & next_mask);
            DONE   <= ev_done;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    property p_rebuild;
        CLK_EN && state == PCW_DECODE && page_ok
        |=> pnum == $past(full_num);
    endproperty
    a_rebuild: assert property (p_rebuild) else $error("pnum wrong"); // RULE16

    property p_low_range;
        CLK_EN && state == PCW_DECODE && idx.page_index == `PCW_PG_0
        |=> pnum < `PCW_LIMIT_LOW;
    endproperty
    a_low_range: assert property (p_low_range) else $error("low pnum"); // RULE1

    property p_high_range;
        CLK_EN && state == PCW_DECODE && page_ok
        && idx.page_index != `PCW_PG_0 |=> pnum >= `PCW_LIMIT_LOW;
    endproperty
    a_high_range: assert property (p_high_range) else $error("hi pnum"); // RULE2

    property p_bad_page;
        CLK_EN && state == PCW_DECODE && !page_ok && !req_none && req_ok
        |=> rsp1[15:12] == `PCW_RSP_ERROR && rsp4 == `PCW_ERR_ILL_PNU;
    endproperty
    a_bad_page: assert property (p_bad_page) else $error("bad page"); // RULE3

    property p_err_id;
        CLK_EN && state == PCW_DECODE && err_any
        |=> rsp1[15:12] == `PCW_RSP_ERROR;
    endproperty
    a_err_id: assert property (p_err_id) else $error("no error id"); // RULE14

    property p_dword;
        CLK_EN && state == PCW_DECODE && is_dword && !err_any
        |=> val_hi == $past(w3) && val_lo == $past(w4);
    endproperty
    a_dword: assert property (p_dword) else $error("dword split"); // RULE8

    property p_word;
        CLK_EN && state == PCW_DECODE && is_word && !req_none && page_ok
        && !is_conn && w3 != 16'h0000 |=> rsp4 == `PCW_ERR_DTYPE;
    endproperty
    a_word: assert property (p_word) else $error("word hi set"); // RULE7

    property p_read;
        CLK_EN && state == PCW_DECODE && is_read |=> val_lo == 16'h0000;
    endproperty
    a_read: assert property (p_read) else $error("read value"); // RULE11

    property p_bad_req;
        CLK_EN && state == PCW_DECODE && !req_ok
        |=> rsp4 == `PCW_ERR_NO_TASK;
    endproperty
    a_bad_req: assert property (p_bad_req) else $error("bad req"); // RULE13

    property p_done;
        CLK_EN && state == PCW_IDLE && go ##1 CLK_EN ##1 CLK_EN
        |=> DONE;
    endproperty
    a_done: assert property (p_done) else $error("done late");

    property p_conn;
        CLK_EN && state == PCW_DECODE && is_conn && !err_any
        |=> val_hi == $past(w3) && val_lo == $past(w4);
    endproperty
    a_conn: assert property (p_conn) else $error("conn split"); // RULE9

    property p_obj;
        CLK_EN && state == PCW_DECODE
        |=> decode[4] == ($past(obj_field) == `PCW_DRIVE_OBJ);
    endproperty
    a_obj: assert property (p_obj) else $error("drive obj"); // RULE12

    property p_subidx;
        CLK_EN && state == PCW_DECODE |=> subidx == $past(sub_field);
    endproperty
    a_subidx: assert property (p_subidx) else $error("subindex"); // RULE5

    property p_lost;
        CLK_EN && go && state != PCW_IDLE |=> status[2];
    endproperty
    a_lost: assert property (p_lost) else $error("lost start");

    property p_irq;
        $past(CLK_EN) |-> IRQ == (|(status & mask));
    endproperty
    a_irq: assert property (p_irq) else $error("irq level");

    property p_rsp_ok;
        CLK_EN && state == PCW_DECODE && !err_any
        |=> rsp1 == $past(w1);
    endproperty
    a_rsp_ok: assert property (p_rsp_ok) else $error("rsp echo"); // RULE14

    property p_answer;
        CLK_EN && state == PCW_DECODE |=> state == PCW_ANSWER;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");

    property p_rdata_idle;
        CLK_EN && !RD |=> RDATA == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata idle");

    c_ok:   cover property (CLK_EN && state == PCW_DECODE && !err_any);
    c_err:  cover property (CLK_EN && ev_err);
    c_irq:  cover property (IRQ);
    c_dw:   cover property (CLK_EN && state == PCW_DECODE && is_dword);
    c_conn: cover property (CLK_EN && state == PCW_DECODE && is_conn);
endmodule
`default_nettype wire

// ===== rtl/pcw_map.svh
/*
 header of named constants for the parameter channel word codec.
 assumes inclusion by bare name from the top module and the testbench.
*/
`ifndef PCW_MAP_SVH
`define PCW_MAP_SVH
`define PCW_ADDR_CTRL     4'h0
`define PCW_ADDR_STATUS   4'h1
`define PCW_ADDR_MASK     4'h2
`define PCW_ADDR_W1       4'h3
`define PCW_ADDR_W2       4'h4
`define PCW_ADDR_W3       4'h5
`define PCW_ADDR_W4       4'h6
`define PCW_ADDR_PNUM     4'h7
`define PCW_ADDR_DECODE   4'h8
`define PCW_ADDR_RSP1     4'h9
`define PCW_ADDR_RSP4     4'hA
`define PCW_ADDR_VAL_HI   4'hB
`define PCW_ADDR_VAL_LO   4'hC
`define PCW_ADDR_SUBIDX   4'hD
`define PCW_PG_0          8'h00
`define PCW_PG_2000       8'h80
`define PCW_PG_6000       8'h90
`define PCW_PG_8000       8'h20
`define PCW_PG_10000      8'hA0
`define PCW_PG_20000      8'h50
`define PCW_PG_30000      8'hF0
`define PCW_PG_60000      8'h74
`define PCW_OFS_2000      16'h07D0
`define PCW_OFS_6000      16'h1770
`define PCW_OFS_8000      16'h1F40
`define PCW_OFS_10000     16'h2710
`define PCW_OFS_20000     16'h4E20
`define PCW_OFS_30000     16'h7530
`define PCW_OFS_60000     16'hEA60
`define PCW_LIMIT_LOW     16'h07D0
`define PCW_DRIVE_OBJ     6'h3F
`define PCW_RSP_ERROR     4'h7
`define PCW_ERR_ILL_PNU   16'h0000
`define PCW_ERR_NO_TASK   16'h006A
`define PCW_ERR_DTYPE     16'h0005
`endif

// ===== rtl/pcw_pkg.sv
/*
 types shared by the parameter channel word codec.
 assumes the map header sits beside it under rtl/.
*/
package pcw_pkg;
    typedef enum logic [3:0] {
        PCW_REQ_NONE  = 4'h0,
        PCW_REQ_READ  = 4'h1,
        PCW_REQ_CHW   = 4'h2,
        PCW_REQ_CHD   = 4'h3,
        PCW_REQ_DESC  = 4'h4,
        PCW_REQ_AREAD = 4'h6,
        PCW_REQ_ACHW  = 4'h7,
        PCW_REQ_ACHD  = 4'h8,
        PCW_REQ_COUNT = 4'h9
    } pcw_req_t;

    typedef struct packed {
        logic [3:0]  request_id_field;
        logic        unused_bit;
        logic [10:0] param_number_field;
    } pcw_key_t;

    typedef struct packed {
        logic [7:0] subindex;
        logic [7:0] page_index;
    } pcw_index_t;

    typedef struct packed {
        logic [5:0] drive_object;
        logic [9:0] conn_index;
    } pcw_conn_t;

    typedef enum logic [2:0] {
        PCW_IDLE   = 3'b001,
        PCW_DECODE = 3'b010,
        PCW_ANSWER = 3'b100
    } pcw_state_t;
endpackage

// ===== verification/pcw_master_model.sv
/*
 fieldbus master model: builds the four request words of a parameter
 request. assumes pcw_pkg is compiled first; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module pcw_master_model
    import pcw_pkg::*;
(
    input  wire logic [15:0] pnum,
    input  wire logic [7:0]  sub,
    input  wire logic [3:0]  rid,
    input  wire logic [2:0]  kind,
    input  wire logic [31:0] val,
    output var  logic [15:0] w1,
    output var  logic [15:0] w2,
    output var  logic [15:0] w3,
    output var  logic [15:0] w4
);
    logic [15:0] ofs;
    logic [7:0]  page;
    pcw_key_t    key;

    always_comb begin
        ofs = 16'h0000;
        page = 8'h00;
        if (pnum >= 16'hEA60) begin ofs = 16'hEA60; page = 8'h74; end
        else if (pnum >= 16'h7530) begin ofs = 16'h7530; page = 8'hF0; end
        else if (pnum >= 16'h4E20) begin ofs = 16'h4E20; page = 8'h50; end
        else if (pnum >= 16'h2710) begin ofs = 16'h2710; page = 8'hA0; end
        else if (pnum >= 16'h1F40) begin ofs = 16'h1F40; page = 8'h20; end
        else if (pnum >= 16'h1770) begin ofs = 16'h1770; page = 8'h90; end
        else if (pnum >= 16'h07D0) begin ofs = 16'h07D0; page = 8'h80; end
    end

    assign key = '{request_id_field: rid, unused_bit: 1'b0,
                   param_number_field: 11'(pnum - ofs)};
    assign w1 = key;
    assign w2 = {sub, page};

    always_comb begin
        case (kind)
            3'h1: {w3, w4} = {16'h0000, 8'h00, val[7:0]};
            3'h2: {w3, w4} = {16'h0000, val[15:0]};
            3'h3: {w3, w4} = val;
            3'h4: {w3, w4} = {val[31:16], 6'h3F, val[9:0]};
            default: {w3, w4} = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

// ===== verification/pcw_codec_tb.sv
/*
 self-checking bench for the parameter channel word codec.
 assumes the register port contract, one 200 MHz clock, no randomness.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcw_map.svh"
module pcw_codec_tb;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        clk_en  = 1'b1;
    logic [3:0]  addr    = 4'h0;
    logic [15:0] wdata   = 16'h0000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [15:0] rdata;
    logic        irq;
    logic        done;
    logic [15:0] pnum    = 16'h0000;
    logic [3:0]  rid     = 4'h0;
    logic [2:0]  kind    = 3'h0;
    logic [31:0] val     = 32'h0000_0000;
    logic [15:0] w1, w2, w3, w4, got, p;
    logic [15:0] ofs_tab [8] = '{16'h0000, 16'h07D0, 16'h1770, 16'h1F40,
                                 16'h2710, 16'h4E20, 16'h7530, 16'hEA60};
    int          error_cnt = 0;
    int          n_tests   = 0;

    always #2.5 sys_clk = ~sys_clk;

    pcw_codec dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .IRQ(irq), .DONE(done));
    pcw_master_model mdl_u (.pnum(pnum), .sub(8'h02), .rid(rid),
        .kind(kind), .val(val), .w1(w1), .w2(w2), .w3(w3), .w4(w4));

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input string s, logic [15:0] e);
        rreg(a);
        chk(s, got, e);
    endtask
    task automatic wait_done(output int n);
        for (n = 0; n < 20 && done !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (done !== 1'b1) begin
            error_cnt++;
            $display("unexpected done: expected 1 seen %b", done);
            wrap_up();
        end
    endtask
    // load the four words from the model, start, time the answer
    task automatic req(input logic [3:0] r, input logic [15:0] pn,
        input logic [2:0] k, input logic [31:0] v, input logic [15:0] x1, x2);
        int n;
        rid = r;
        pnum = pn;
        kind = k;
        val = v;
        #1;
        wreg(`PCW_ADDR_W1, w1 ^ x1);
        wreg(`PCW_ADDR_W2, w2 ^ x2);
        wreg(`PCW_ADDR_W3, w3);
        wreg(`PCW_ADDR_W4, w4);
        wreg(`PCW_ADDR_CTRL, 16'h0001);
        wait_done(n);
        chk("done latency", 16'(n), 16'h0002);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk(`PCW_ADDR_STATUS, "status reset", 16'h0000);
        chk("irq reset", {15'h0000, irq}, 16'h0000);
        // bottom and top of every page range
        for (int j = 0; j < 16; j++) begin
            p = ofs_tab[j / 2] + ((j % 2) ? 16'h07CF : 16'h0000);
            req(4'h6, p, 3'h0, 32'h0, 16'h0000, 16'h0000);
            rchk(`PCW_ADDR_PNUM, "number", p);
            rchk(`PCW_ADDR_DECODE, "decode", 16'h0007);
            rchk(`PCW_ADDR_RSP1, "echo", w1);
            rchk(`PCW_ADDR_SUBIDX, "subindex", 16'h0002);
        end
        // every request code, listed or not
        for (int r = 0; r < 16; r++) begin
            req(4'(r), 16'h0100, 3'h0, 32'h0, 16'h0000, 16'h0000);
            rreg(`PCW_ADDR_DECODE);
            chk("req ok", got & 16'h0001, 16'((r <= 9) && (r != 5)));
            if (r > 9 || r == 5) begin
                rchk(`PCW_ADDR_RSP4, "errno", `PCW_ERR_NO_TASK);
                rreg(`PCW_ADDR_RSP1);
                chk("rsp id", got >> 12, 16'h0007);
            end
        end
        req(4'h6, 16'h0731, 3'h0, 32'h0, 16'h0800, 16'h0000);
        rchk(`PCW_ADDR_PNUM, "bit11", 16'h0731);
        rchk(`PCW_ADDR_DECODE, "bit11 dec", 16'h0007);
        req(4'h2, 16'h0100, 3'h1, 32'hFFFF_FF5A, 16'h0000, 16'h0000);
        rchk(`PCW_ADDR_VAL_LO, "byte", 16'h005A);
        rchk(`PCW_ADDR_VAL_HI, "byte hi", 16'h0000);
        req(4'h7, 16'h04BA, 3'h2, 32'h0000_001A, 16'h0000, 16'h0000);
        rchk(`PCW_ADDR_VAL_LO, "word", 16'h001A);
        req(4'h2, 16'h0100, 3'h3, 32'h0001_0002, 16'h0000, 16'h0000);
        rchk(`PCW_ADDR_RSP4, "w3 set", `PCW_ERR_DTYPE);
        req(4'h8, 16'h0200, 3'h3, 32'h1234_ABCD, 16'h0000, 16'h0000);
        rchk(`PCW_ADDR_VAL_HI, "dw hi", 16'h1234);
        rchk(`PCW_ADDR_VAL_LO, "dw lo", 16'hABCD);
        rchk(`PCW_ADDR_DECODE, "dw dec", 16'h000B);
        req(4'h7, 16'h0348, 3'h4, 32'h02D2_0002, 16'h0000, 16'h0000);
        rchk(`PCW_ADDR_DECODE, "conn", 16'h0013);
        rchk(`PCW_ADDR_VAL_HI, "conn src", 16'h02D2);
        rchk(`PCW_ADDR_VAL_LO, "conn obj", 16'hFC02);
        rchk(`PCW_ADDR_RSP1, "conn echo", w1);
        // interrupt: clear, unmask error, raise, clear again
        wreg(`PCW_ADDR_STATUS, 16'h0007);
        rchk(`PCW_ADDR_STATUS, "w1c", 16'h0000);
        wreg(`PCW_ADDR_MASK, 16'h0002);
        req(4'h6, 16'h0100, 3'h0, 32'h0, 16'h0000, 16'h0011);
        rchk(`PCW_ADDR_RSP4, "bad page", `PCW_ERR_ILL_PNU);
        chk("irq on", {15'h0000, irq}, 16'h0001);
        wreg(`PCW_ADDR_STATUS, 16'h0002);
        rchk(`PCW_ADDR_STATUS, "done kept", 16'h0001);
        chk("irq masked", {15'h0000, irq}, 16'h0000);
        // start while busy
        wreg(`PCW_ADDR_CTRL, 16'h0001);
        wreg(`PCW_ADDR_CTRL, 16'h0001);
        #1 chk("busy done", {15'h0000, done}, 16'h0001);
        repeat (2) @(posedge sys_clk);
        #1 chk("refused", {15'h0000, done}, 16'h0000);
        rreg(`PCW_ADDR_STATUS);
        chk("busy", got & 16'h0004, 16'h0004);
        rchk(4'hF, "unmapped", 16'h0000);
        clk_en <= 1'b0;
        wreg(`PCW_ADDR_MASK, 16'h0007);
        clk_en <= 1'b1;
        rchk(`PCW_ADDR_MASK, "frozen", 16'h0002);
        wrap_up();
    end
endmodule
`default_nettype wire
